// *** verilog/adc_ctrl_pkg.sv ***
// Shared constants, register map and types of the converter control block
package adc_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRLA = 8'h00;
    localparam logic [7:0] OFF_CTRLB = 8'h04;
    localparam logic [7:0] OFF_CTRLC = 8'h08;
    localparam logic [7:0] OFF_CTRLD = 8'h0C;
    localparam logic [7:0] OFF_POS_SEL = 8'h10;
    localparam logic [7:0] OFF_NEG_SEL = 8'h14;
    localparam logic [7:0] OFF_COMMAND = 8'h18;
    localparam logic [7:0] OFF_EVCTRL = 8'h1C;
    localparam logic [7:0] OFF_INTCTRL = 8'h20;
    localparam logic [7:0] OFF_INTFLAGS = 8'h24;
    localparam logic [7:0] OFF_RESULT = 8'h28;
    // Field positions and widths
    localparam int CTRLA_ENABLE = 0;
    localparam int CTRLA_FREE_RUNNING = 1;
    localparam int CTRLA_RESOLUTION = 2;
    localparam int CTRLA_LEFT_ADJUST = 3;
    localparam int CTRLA_CONV_MODE = 4;
    localparam int CTRLB_TRUNCATE = 3;
    localparam int SEL_W = 7;
    localparam int DATA_W = 12;
    localparam int RES_W = 16;
    localparam int ACC_W = 19;
    // Converter clock cycles per phase; half cycle of conversion rounded up
    localparam logic [7:0] SAMPLE_TICKS = 8'h02;
    localparam logic [7:0] CONVERT_TICKS = 8'h0E;
    typedef struct packed {
        logic enable;
        logic free_running;
        logic resolution_select;
        logic left_adjust;
        logic conversion_mode;
        logic [2:0] sample_count;
        logic truncate;
        logic [2:0] prescaler_select;
        logic [7:0] init_delay;
        logic [SEL_W-1:0] positive_input_select;
        logic [SEL_W-1:0] negative_input_select;
        logic start_event_input;
        logic ready_irq_enable;
    } ctrl_t;
    localparam ctrl_t CTRL_RESET = '0;
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_INIT, S_SAMPLE, S_CONVERT, S_ACCUM, S_DONE
    } conv_state_t;
endpackage

// *** verilog/adc_prescaler.sv ***
// Converter clock enable divider, held in reset while idle
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic [2:0] select,
    // Converter clock enable
    output logic tick
);
    logic [7:0] count;
    logic [7:0] last;

    // Divide by 2^(select+1); select 7 wraps to 255 on purpose
    assign last = 8'((8'h02 << select) - 8'h01);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (!run) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count == last) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= 8'(count + 8'h01);
            tick <= 1'b0;
        end
    end

    a_tick_idle: assert property (@(posedge clk) disable iff (!rst_n) !run |=> !tick)
        else $error("prescaler ticked while held");
endmodule
`default_nettype wire

// *** verilog/adc_accumulator.sv ***
// Sample accumulator and result formatting
`timescale 1ns/1ps
`default_nettype none
module adc_accumulator (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sequencing
    input wire logic clear,
    input wire logic add,
    input wire logic finish,
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] sample,
    // Format settings
    input wire logic [2:0] sample_count,
    input wire logic truncate,
    input wire logic differential,
    input wire logic res10,
    input wire logic left_adjust,
    // Result
    output logic [adc_ctrl_pkg::RES_W-1:0] result
);
    import adc_ctrl_pkg::*;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] ext;
    logic signed [ACC_W-1:0] val;
    logic [RES_W-1:0] next_result;

    // Differential samples are two's complement, single-ended unsigned
    assign ext = differential ? ACC_W'(signed'(sample)) : ACC_W'(sample);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
        end else if (clear) begin
            acc <= '0;
        end else if (add) begin
            acc <= ACC_W'(acc + ext);
        end
    end

    always_comb begin
        val = acc;
        if (sample_count != 3'h0) begin
            // Truncation keeps the mean; without it the low 16 bits of the sum
            val = truncate ? (acc >>> sample_count) : acc;
        end else if (res10) begin
            val = acc >>> 2;
        end
        next_result = val[RES_W-1:0];
        if (left_adjust && sample_count == 3'h0) begin
            next_result = val[RES_W-1:0] << (res10 ? 6 : 4);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
        end else if (finish) begin
            result <= next_result;
        end
    end

    a_acc_clear: assert property (@(posedge clk) disable iff (!rst_n) clear |=> acc == '0)
        else $error("accumulator not cleared");
endmodule
`default_nettype wire

// *** verilog/adc_conversion_control.sv ***
// Converter sequencing, triggers and AHB-Lite register file
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Event input
    input wire logic start_event,
    // Analog core
    input wire logic [adc_ctrl_pkg::DATA_W-1:0] core_result,
    output logic adc_clk_tick,
    output logic core_sample,
    output logic core_convert,
    output logic core_differential,
    output logic [adc_ctrl_pkg::SEL_W-1:0] core_positive_select,
    output logic [adc_ctrl_pkg::SEL_W-1:0] core_negative_select,
    // Status
    output logic result_ready_irq,
    output logic result_ready_event
);
    import adc_ctrl_pkg::*;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ctrl_t cfg;
    conv_state_t state;
    conv_state_t next_state;
    logic dp_write;
    logic [7:0] dp_addr;
    logic accept;
    logic cmd_start;
    logic event_prev;
    logic event_start;
    logic trigger_ok;
    logic busy;
    logic result_ready;
    logic enable_prev;
    logic init_pending;
    logic [7:0] tick_count;
    logic [6:0] sample_index;
    logic [6:0] last_index;
    logic [RES_W-1:0] result;
    logic [31:0] rd_value;
    logic ready_clear;

    // Bus side
    assign accept = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hready) begin
            dp_write <= accept && hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Unmapped offsets read as zero
    always_comb begin
        rd_value = 32'h0;
        case (haddr[7:0])
            OFF_CTRLA: rd_value = {27'h0, cfg.conversion_mode, cfg.left_adjust, cfg.resolution_select,
                                   cfg.free_running, cfg.enable};
            OFF_CTRLB: rd_value = {28'h0, cfg.truncate, cfg.sample_count};
            OFF_CTRLC: rd_value = {29'h0, cfg.prescaler_select};
            OFF_CTRLD: rd_value = {24'h0, cfg.init_delay};
            OFF_POS_SEL: rd_value = {25'h0, cfg.positive_input_select};
            OFF_NEG_SEL: rd_value = {25'h0, cfg.negative_input_select};
            OFF_COMMAND: rd_value = {31'h0, busy};
            OFF_EVCTRL: rd_value = {31'h0, cfg.start_event_input};
            OFF_INTCTRL: rd_value = {31'h0, cfg.ready_irq_enable};
            OFF_INTFLAGS: rd_value = {31'h0, result_ready};
            OFF_RESULT: rd_value = {16'h0, result};
            default: rd_value = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (accept && !hwrite) begin
            hrdata <= rd_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= CTRL_RESET;
        end else if (dp_write) begin
            case (dp_addr)
                OFF_CTRLA: begin
                    cfg.enable <= hwdata[CTRLA_ENABLE];
                    cfg.free_running <= hwdata[CTRLA_FREE_RUNNING];
                    cfg.resolution_select <= hwdata[CTRLA_RESOLUTION];
                    cfg.left_adjust <= hwdata[CTRLA_LEFT_ADJUST];
                    cfg.conversion_mode <= hwdata[CTRLA_CONV_MODE];
                end
                OFF_CTRLB: begin
                    cfg.sample_count <= hwdata[2:0];
                    cfg.truncate <= hwdata[CTRLB_TRUNCATE];
                end
                OFF_CTRLC: cfg.prescaler_select <= hwdata[2:0];
                OFF_CTRLD: cfg.init_delay <= hwdata[7:0];
                OFF_POS_SEL: cfg.positive_input_select <= hwdata[SEL_W-1:0];
                OFF_NEG_SEL: cfg.negative_input_select <= hwdata[SEL_W-1:0];
                OFF_EVCTRL: cfg.start_event_input <= hwdata[0];
                OFF_INTCTRL: cfg.ready_irq_enable <= hwdata[0];
                default: cfg <= cfg;
            endcase
        end
    end

    // Triggers
    assign cmd_start = dp_write && dp_addr == OFF_COMMAND && hwdata[0];
    assign ready_clear = dp_write && dp_addr == OFF_INTFLAGS && hwdata[0];
    // Event network runs on this clock, so no synchroniser
    assign event_start = cfg.start_event_input && start_event && !event_prev;
    // Only an idle, enabled converter accepts a trigger
    assign trigger_ok = cfg.enable && state == S_IDLE && (cmd_start || event_start);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_prev <= 1'b0;
        end else begin
            event_prev <= start_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
        end else if (!cfg.enable) begin
            busy <= 1'b0;
        end else if (trigger_ok) begin
            busy <= 1'b1;
        end else if (state == S_DONE && !cfg.free_running) begin
            busy <= 1'b0;
        end
    end

    // Warm-up wait armed on each enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_prev <= 1'b0;
            init_pending <= 1'b0;
        end else begin
            enable_prev <= cfg.enable;
            if (cfg.enable && !enable_prev) begin
                init_pending <= 1'b1;
            end else if (state == S_SAMPLE) begin
                init_pending <= 1'b0;
            end
        end
    end

    // Sequencer
    assign last_index = 7'((8'h01 << cfg.sample_count) - 8'h01);

    always_comb begin
        next_state = state;
        case (state)
            S_IDLE: begin
                if (trigger_ok) begin
                    next_state = S_START;
                end
            end
            S_START: begin
                next_state = (init_pending && cfg.init_delay != 8'h00) ? S_INIT : S_SAMPLE;
            end
            S_INIT: begin
                if (adc_clk_tick && tick_count == 8'(cfg.init_delay - 8'h01)) begin
                    next_state = S_SAMPLE;
                end
            end
            S_SAMPLE: begin
                if (adc_clk_tick && tick_count == 8'(SAMPLE_TICKS - 8'h01)) begin
                    next_state = S_CONVERT;
                end
            end
            S_CONVERT: begin
                if (adc_clk_tick && tick_count == 8'(CONVERT_TICKS - 8'h01)) begin
                    next_state = S_ACCUM;
                end
            end
            S_ACCUM: begin
                next_state = (sample_index == last_index) ? S_DONE : S_SAMPLE;
            end
            S_DONE: begin
                next_state = cfg.free_running ? S_START : S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
        if (!cfg.enable) begin
            next_state = S_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_count <= 8'h00;
        end else if (next_state != state) begin
            tick_count <= 8'h00;
        end else if (adc_clk_tick) begin
            tick_count <= 8'(tick_count + 8'h01);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_index <= 7'h00;
        end else if (state == S_START) begin
            sample_index <= 7'h00;
        end else if (state == S_ACCUM) begin
            sample_index <= 7'(sample_index + 7'h01);
        end
    end

    // Channel and mode are latched per conversion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_positive_select <= '0;
            core_negative_select <= '0;
            core_differential <= 1'b0;
        end else if (next_state == S_START) begin
            core_positive_select <= cfg.positive_input_select;
            core_negative_select <= cfg.negative_input_select;
            core_differential <= cfg.conversion_mode;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_sample <= 1'b0;
            core_convert <= 1'b0;
            result_ready_event <= 1'b0;
        end else begin
            core_sample <= next_state == S_SAMPLE;
            core_convert <= next_state == S_CONVERT;
            result_ready_event <= state == S_DONE;
        end
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ready <= 1'b0;
        end else if (state == S_DONE) begin
            result_ready <= 1'b1;
        end else if (ready_clear) begin
            result_ready <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ready_irq <= 1'b0;
        end else begin
            result_ready_irq <= result_ready && cfg.ready_irq_enable;
        end
    end

    // Held in DONE so a free-running restart also restarts the divider
    adc_prescaler u_prescaler (
        .clk(hclk),
        .rst_n(hresetn),
        .run(state != S_IDLE && state != S_DONE),
        .select(cfg.prescaler_select),
        .tick(adc_clk_tick)
    );

    adc_accumulator u_accumulator (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(state == S_START),
        .add(state == S_ACCUM),
        .finish(state == S_DONE),
        .sample(core_result),
        .sample_count(cfg.sample_count),
        .truncate(cfg.truncate),
        .differential(core_differential),
        .res10(cfg.resolution_select),
        .left_adjust(cfg.left_adjust),
        .result(result)
    );

    a_start_delay: assert property (trigger_ok |=> state == S_START)
        else $error("conversion did not start one cycle after trigger");
    a_fixed_latency: assert property (trigger_ok |=> ##1 (state == S_INIT || state == S_SAMPLE))
        else $error("trigger to sampling latency wrong");
    a_busy_bit: assert property ((state != S_IDLE && state != S_DONE) |-> busy)
        else $error("start bit low during conversion");
    a_ready_set: assert property (state == S_DONE |=> result_ready && result_ready_event)
        else $error("result ready not set on completion");
    a_irq_gate: assert property ($rose(result_ready_irq) |-> $past(cfg.ready_irq_enable))
        else $error("interrupt raised while disabled");
    a_disabled_idle: assert property (!cfg.enable |=> state == S_IDLE && !busy)
        else $error("converter active while disabled");
    a_no_restart: assert property (state == S_CONVERT && cfg.enable |=> state == S_CONVERT || state == S_ACCUM)
        else $error("conversion disturbed");
    a_free_run: assert property (state == S_DONE && cfg.free_running && cfg.enable |=> state == S_START)
        else $error("free running did not restart");
    a_chan_hold: assert property (state == S_CONVERT |-> $stable(core_positive_select))
        else $error("channel changed mid conversion");
    a_idle_tick: assert property (state == S_IDLE && $past(state == S_IDLE) |-> !adc_clk_tick)
        else $error("converter clock ran while idle");
endmodule
`default_nettype wire

// *** tb/adc_core_model.sv ***
// Behavioural model of the analog converter core
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Core controls
    input wire logic core_sample,
    input wire logic core_convert,
    input wire logic core_differential,
    input wire logic [6:0] positive_select,
    // Sample out
    output logic [11:0] core_result
);
    logic [11:0] held;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held <= 12'h000;
        end else if (core_convert) begin
            // Differential reads negative, single-ended unsigned
            held <= core_differential ? {5'h10, positive_select} : {positive_select, 5'h15};
        end else if (core_sample) begin
            // Garbage while tracking, so a stale value never passes
            held <= ~held;
        end
    end
    assign core_result = held;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adc_ctrl_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, start_event = 0;
    logic [31:0] haddr = '0, hwdata = '0, rd;
    logic [1:0] htrans = 2'b00;
    wire logic hreadyout, hresp, adc_clk_tick, core_sample, core_convert, core_differential;
    wire logic result_ready_irq, result_ready_event;
    wire logic [31:0] hrdata;
    wire logic [11:0] core_result;
    wire logic [6:0] pos_sel, neg_sel;
    int err_count = 0, cmp_count = 0, ev_count = 0, tick_count = 0, lat_cmd, lat_evt;
    adc_conversion_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .start_event(start_event), .core_result(core_result),
        .adc_clk_tick(adc_clk_tick), .core_sample(core_sample), .core_convert(core_convert),
        .core_differential(core_differential), .core_positive_select(pos_sel),
        .core_negative_select(neg_sel), .result_ready_irq(result_ready_irq),
        .result_ready_event(result_ready_event));
    adc_core_model core (.hclk(hclk), .hresetn(hresetn), .core_sample(core_sample), .core_convert(core_convert),
        .core_differential(core_differential), .positive_select(pos_sel), .core_result(core_result));
    initial forever #5 hclk = ~hclk;
    // Counted on the falling edge, clear of register updates
    always @(negedge hclk) begin
        if (result_ready_event === 1'b1) ev_count++;
        if (adc_clk_tick === 1'b1) tick_count++;
    end
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    // Idle cycle first: read-back right after a write sees the old value
    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= 1'b0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        rdr(a, rd);
        check(name, exp, rd);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rdr(OFF_COMMAND, rd);
            n++;
        end while (rd[0] !== 1'b0 && n < 500);
        // A conversion that never ends must not pass silently
        check("conversion finished", 32'h0, rd);
    endtask
    task automatic lat(output int n);
        n = 0;
        do begin
            @(posedge hclk);
            #1;
            n++;
        end while (core_sample !== 1'b1 && n < 10);
    endtask
    task automatic conv(input string name, input logic [31:0] ctrla, input logic [31:0] ctrlb, input logic [31:0] exp);
        wr(OFF_CTRLA, ctrla);
        wr(OFF_CTRLB, ctrlb);
        wr(OFF_COMMAND, 32'h1);
        wait_idle;
        rchk(name, OFF_RESULT, exp);
    endtask
    task automatic t_reset;
        rchk("ctrla", OFF_CTRLA, 32'h0);
        rchk("flags", OFF_INTFLAGS, 32'h0);
        rchk("result", OFF_RESULT, 32'h0);
        rchk("unmapped", 8'h3C, 32'h0);
        check("okay response", 32'h0, hresp);
    endtask
    task automatic t_disabled;
        int t0;
        t0 = tick_count;
        wr(OFF_COMMAND, 32'h1);
        rchk("busy while off", OFF_COMMAND, 32'h0);
        repeat (20) @(posedge hclk);
        #1 check("sample while off", 32'h0, core_sample);
        check("idle ticks", 32'h0, tick_count - t0);
    endtask
    task automatic t_single;
        int e0;
        wr(OFF_CTRLC, 32'h0);
        wr(OFF_POS_SEL, 32'h3);
        wr(OFF_NEG_SEL, 32'h2);
        wr(OFF_CTRLA, 32'h1);
        e0 = ev_count;
        wr(OFF_COMMAND, 32'h1);
        lat(lat_cmd);
        check("start latency", 32'h1, lat_cmd);
        rchk("busy", OFF_COMMAND, 32'h1);
        wr(OFF_COMMAND, 32'h1);
        wr(OFF_POS_SEL, 32'h5);
        check("channel held", 32'h3, pos_sel);
        check("negative held", 32'h2, neg_sel);
        wait_idle;
        rchk("single result", OFF_RESULT, 32'h75);
        check("one result", 32'h1, ev_count - e0);
        rchk("flag polled", OFF_INTFLAGS, 32'h1);
        check("irq masked", 32'h0, result_ready_irq);
    endtask
    task automatic t_irq;
        wr(OFF_INTFLAGS, 32'h1);
        wr(OFF_INTCTRL, 32'h1);
        wr(OFF_COMMAND, 32'h1);
        wait_idle;
        rchk("new channel", OFF_RESULT, 32'hB5);
        repeat (2) @(posedge hclk);
        #1 check("irq raised", 32'h1, result_ready_irq);
        wr(OFF_INTFLAGS, 32'h1);
        repeat (2) @(posedge hclk);
        #1 check("irq cleared", 32'h0, result_ready_irq);
        wr(OFF_INTCTRL, 32'h0);
    endtask
    task automatic t_event;
        wr(OFF_EVCTRL, 32'h1);
        start_event <= 1'b1;
        lat(lat_evt);
        // Event seen one edge after it is driven
        check("event latency", 32'h2, lat_evt);
        rchk("event busy", OFF_COMMAND, 32'h1);
        wait_idle;
        start_event <= 1'b0;
        wr(OFF_EVCTRL, 32'h0);
        start_event <= 1'b1;
        rchk("event ignored", OFF_COMMAND, 32'h0);
        start_event <= 1'b0;
    endtask
    task automatic t_free;
        int e0;
        e0 = ev_count;
        wr(OFF_CTRLA, 32'h3);
        wr(OFF_COMMAND, 32'h1);
        for (int n = 0; n < 2000 && ev_count - e0 < 2; n++) @(posedge hclk);
        check("free results", 32'h1, ev_count - e0 >= 2);
        rchk("free busy", OFF_COMMAND, 32'h1);
        wr(OFF_CTRLA, 32'h1);
        wait_idle;
        rchk("free result", OFF_RESULT, 32'hB5);
    endtask
    task automatic t_init;
        int n;
        wr(OFF_CTRLA, 32'h0);
        wr(OFF_CTRLC, 32'h1);
        wr(OFF_CTRLD, 32'h2);
        wr(OFF_CTRLA, 32'h1);
        wr(OFF_COMMAND, 32'h1);
        lat(n);
        // One start cycle, then two ticks of a divide-by-four clock
        check("init delay", 32'h9, n);
        wait_idle;
        wr(OFF_COMMAND, 32'h1);
        lat(n);
        // Warm-up only applies to the first conversion after enable
        check("init once", 32'h1, n);
        wait_idle;
        wr(OFF_CTRLD, 32'h0);
        wr(OFF_CTRLC, 32'h0);
    endtask
    task automatic t_format;
        conv("accumulated", 32'h1, 32'h2, 32'h2D4);
        conv("accumulated again", 32'h1, 32'h2, 32'h2D4);
        conv("truncated", 32'h1, 32'hA, 32'hB5);
        conv("ten bit", 32'h5, 32'h0, 32'h2D);
        conv("left twelve", 32'h9, 32'h0, 32'hB50);
        conv("left ten", 32'hD, 32'h0, 32'hB40);
        conv("differential", 32'h11, 32'h0, 32'hF805);
    endtask
    // Whole run is about a thousand cycles
    initial begin
        #500000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_disabled();
        t_single();
        t_irq();
        t_event();
        t_free();
        t_init();
        t_format();
        end_of_test();
    end
endmodule
`default_nettype wire
